// ===== verilog/ref_clock_select_and_reset.sv
// Overview of operation
// - Strap 00/01/10 picks differential 156.25/125/25 MHz, 11 picks 25 MHz crystal.
// - Device held in reset while hardware reset is low; after it goes high, runs once the picked source has given 10 rising edges.
// - Crystal input, when selected, is treated as a 25 MHz source.
// - Interrupt output pulls low when pending, otherwise released, never driven high.
// - Boundary-scan logic held in reset while test reset input is low.
`timescale 1ns/1ns
`default_nettype none

module ref_clock_select_and_reset
  import clk_rst_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [STRAP_W-1:0] clkSelStrap,
  input  wire logic              differentialReferenceClock,
  input  wire logic              crystalClockInput,
  input  wire logic              irqPending,
  input  wire logic              testResetLow,
  output var  logic              selCrystal,
  output var  ref_freq_t         refFreq,
  output var  logic              coreResetLow,
  output var  logic              irqOutLowO,
  output var  logic              irqOutLowOe,
  output var  logic              scanLogicReset
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] resetSync;
    seq_state_t             state;
    logic [STRAP_W-1:0]     strap;
    logic                   selCrystal;
    ref_freq_t              refFreq;
    logic                   coreResetLow;
    logic                   irqOe;
  } top_state_t;

  localparam top_state_t RESET_STATE = '{
    resetSync:    '0,
    state:        ST_HOLD,
    strap:        SEL_DIFF_156,
    selCrystal:   1'b0,
    refFreq:      FREQ_156M25,
    coreResetLow: 1'b0,
    irqOe:        1'b0
  };

  top_state_t q;
  top_state_t next_q;
  clk_seq_if  link ();

  logic resetReleased;

  assign resetReleased = q.resetSync[SYNC_STAGES-1];

  toggle_qualifier #(
    .MIN_TOGGLES (MIN_CLK_TOGGLES),
    .CNT_W       (TOGGLE_CNT_W)
  ) u_qualifier (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .link    (link)
  );

  // Edge counting only watches the source the strap picked
  assign link.srcLevel    = q.selCrystal ? crystalClockInput : differentialReferenceClock;
  assign link.countEnable = (q.state == ST_QUALIFY);

  always_comb
  begin
    next_q           = q;
    // Shift register: stage 0 feeds only stage 1
    next_q.resetSync = {q.resetSync[SYNC_STAGES-2:0], 1'b1};
    next_q.irqOe     = irqPending;
    unique case (q.state)
      ST_HOLD:
      begin
        next_q.coreResetLow = 1'b0;
        // Strap sampled by a clocked process after release, never under reset
        if (resetReleased)
        begin
          next_q.strap = clkSelStrap;
          next_q.state = ST_QUALIFY;
          unique case (clkSelStrap)
            SEL_DIFF_156:
            begin
              next_q.selCrystal = 1'b0;
              next_q.refFreq    = FREQ_156M25;
            end
            SEL_DIFF_125:
            begin
              next_q.selCrystal = 1'b0;
              next_q.refFreq    = FREQ_125M;
            end
            SEL_DIFF_25:
            begin
              next_q.selCrystal = 1'b0;
              next_q.refFreq    = FREQ_25M;
            end
            SEL_XTAL_25:
            begin
              next_q.selCrystal = 1'b1;
              next_q.refFreq    = FREQ_25M;
            end
          endcase
        end
      end
      ST_QUALIFY:
      begin
        // Guards against a late clock even though the board should already provide it
        if (link.qualified)
        begin
          next_q.state        = ST_RUN;
          next_q.coreResetLow = 1'b1;
        end
      end
      ST_RUN:
      begin
        next_q.coreResetLow = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= RESET_STATE;
    else
      q <= next_q;
  end

  assign selCrystal   = q.selCrystal;
  assign refFreq      = q.refFreq;
  assign coreResetLow = q.coreResetLow;
  // Open drain: data always low, only the enable moves
  assign irqOutLowO   = 1'b0;
  assign irqOutLowOe  = q.irqOe;
  // Kept combinational so scan reset acts without a running reference
  assign scanLogicReset = ~testResetLow;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence relRise;
    $rose(resetReleased);
  endsequence

  sequence enterQualify;
    q.state == ST_QUALIFY;
  endsequence

  sequence qualifiedSeen;
    link.qualified && q.state == ST_QUALIFY;
  endsequence

  property strapToFreq(logic [1:0] code, ref_freq_t f, logic xtal);
    (q.state != ST_HOLD && q.strap == code) |-> (refFreq == f && selCrystal == xtal);
  endproperty

  chk_strap_156_decode: assert property (strapToFreq(SEL_DIFF_156, FREQ_156M25, 1'b0))
    else $error("strap 00 decoded wrongly");

  chk_strap_125_decode: assert property (strapToFreq(SEL_DIFF_125, FREQ_125M, 1'b0))
    else $error("strap 01 decoded wrongly");

  chk_strap_25_decode: assert property (strapToFreq(SEL_DIFF_25, FREQ_25M, 1'b0))
    else $error("strap 10 decoded wrongly");

  chk_crystal_freq: assert property (strapToFreq(SEL_XTAL_25, FREQ_25M, 1'b1))
    else $error("crystal source not treated as 25 MHz");

  chk_reset_holds: assert property (@(posedge ref_clk) disable iff (1'b0)
      !reset_n |-> !coreResetLow)
    else $error("core left reset while hardware reset low");

  chk_sync_release: assert property (relRise |=> enterQualify)
    else $error("no qualify step after synchronised release");

  chk_release_path: assert property ($rose(coreResetLow) |->
      ($past(q.state) == ST_QUALIFY && resetReleased && $past(link.qualified)))
    else $error("core reset released off sequence");

  chk_run_after_qual: assert property (qualifiedSeen |=> (coreResetLow && q.state == ST_RUN))
    else $error("qualified clock did not release core");

  chk_irq_drive: assert property (irqPending |=> (irqOutLowOe && !irqOutLowO))
    else $error("pending interrupt not pulled low");

  chk_irq_release: assert property (!irqPending |=> !irqOutLowOe)
    else $error("interrupt output driven with nothing pending");

  // Scan reset ignores the hardware reset, so these two stay armed while it is low
  chk_scan_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
      !testResetLow |-> scanLogicReset)
    else $error("scan logic not in reset");

  chk_scan_release: assert property (@(posedge ref_clk) disable iff (1'b0)
      testResetLow |-> !scanLogicReset)
    else $error("scan logic held in reset with test reset high");

  chk_strap_locked: assert property ((q.state != ST_HOLD) |=> ($stable(refFreq) && $stable(selCrystal)))
    else $error("strap decode changed after capture");

  chk_hold_no_run: assert property ((q.state != ST_RUN) |-> !coreResetLow)
    else $error("core out of reset before run state");

  chk_early_capture: assert property ((q.state == ST_HOLD && !resetReleased) |=> q.state == ST_HOLD)
    else $error("strap captured before synchronised release");

  // Waiting on the source is the whole point of qualify; a leak here defeats it
  chk_qualify_wait: assert property ((enterQualify and !link.qualified) |=> !coreResetLow)
    else $error("core released before source edges counted");

  chk_irq_data_low: assert property (!irqOutLowO)
    else $error("interrupt output data not low");

endmodule : ref_clock_select_and_reset

`default_nettype wire

// ===== verilog/clk_rst_pkg.sv
package clk_rst_pkg;

  // Strap codes for the reference clock source
  localparam int          STRAP_W      = 2;
  localparam logic [1:0]  SEL_DIFF_156 = 2'h0;
  localparam logic [1:0]  SEL_DIFF_125 = 2'h1;
  localparam logic [1:0]  SEL_DIFF_25  = 2'h2;
  localparam logic [1:0]  SEL_XTAL_25  = 2'h3;

  // Frequency reported for the chosen source
  typedef enum logic [1:0] {
    FREQ_156M25 = 2'h0,
    FREQ_125M   = 2'h1,
    FREQ_25M    = 2'h2
  } ref_freq_t;

  // Reset release sequence
  typedef enum logic [2:0] {
    ST_HOLD    = 3'h1,
    ST_QUALIFY = 3'h2,
    ST_RUN     = 3'h4
  } seq_state_t;

  localparam int MIN_CLK_TOGGLES = 10;
  localparam int TOGGLE_CNT_W    = 4;
  localparam int SYNC_STAGES     = 2;

endpackage : clk_rst_pkg

// ===== verilog/clk_seq_if.sv
`timescale 1ns/1ns
`default_nettype none

interface clk_seq_if;
  logic srcLevel;
  logic countEnable;
  logic qualified;

  modport seq (output srcLevel, output countEnable, input qualified);
  modport qual (input srcLevel, input countEnable, output qualified);
endinterface : clk_seq_if

`default_nettype wire

// ===== verilog/toggle_qualifier.sv
`timescale 1ns/1ns
`default_nettype none

module toggle_qualifier
  import clk_rst_pkg::*;
#(
  parameter int MIN_TOGGLES = MIN_CLK_TOGGLES,
  parameter int CNT_W       = TOGGLE_CNT_W
)
(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  clk_seq_if.qual   link
);

  typedef struct packed {
    logic             lastLevel;
    logic [CNT_W-1:0] count;
    logic             qualified;
  } qual_state_t;

  localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(MIN_TOGGLES);

  qual_state_t q;
  qual_state_t next_q;

  // Counts rising edges of the chosen source; saturates at the threshold
  always_comb
  begin
    next_q           = q;
    next_q.lastLevel = link.srcLevel;
    if (!link.countEnable)
    begin
      // Held high while idle so a switch of the source mux never counts as an edge
      next_q.lastLevel = 1'b1;
      next_q.count     = '0;
      next_q.qualified = 1'b0;
    end
    else
    begin
      if (link.srcLevel && !q.lastLevel && (q.count < MIN_CNT))
        next_q.count = q.count + 1'b1;
      next_q.qualified = (next_q.count >= MIN_CNT);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign link.qualified = q.qualified;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  chk_min_toggles: assert property ($rose(q.qualified) |-> q.count == MIN_CNT)
    else $error("qualified before enough source edges");

  chk_count_clear: assert property (!link.countEnable |=> (q.count == '0 && !q.qualified))
    else $error("toggle count not cleared while disabled");

endmodule : toggle_qualifier

`default_nettype wire

// ===== bench/board_clock_source.sv
`timescale 1ns/1ns
`default_nettype none

module board_clock_source
(
  input  wire logic ref_clk,
  input  wire logic diffRun,
  input  wire logic xtalRun,
  output var  logic diffClk,
  output var  logic xtalClk,
  output var  logic srcReady
);
  // Sources toggle every fourth edge so the sampled level is never aliased
  logic [1:0] phase = 2'h0;
  logic [3:0] rises = 4'h0;
  logic       dClk  = 1'b0;
  logic       xClk  = 1'b0;
  logic       ready = 1'b0;

  assign diffClk  = dClk;
  assign xtalClk  = xClk;
  assign srcReady = ready;

  // A stopped source stands still low
  always @(posedge ref_clk)
  begin
    if (!diffRun && !xtalRun)
    begin
      phase <= 2'h0;
      rises <= 4'h0;
      dClk  <= 1'b0;
      xClk  <= 1'b0;
      ready <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      if (phase == 2'h3)
      begin
        dClk <= diffRun & ~dClk;
        xClk <= xtalRun & ~xClk;
        if (!dClk && !xClk && rises != 4'hF)
          rises <= rises + 4'h1;
      end
      // Ten full periods need an eleventh rising edge
      ready <= (rises > 4'hA);
    end
  end
endmodule : board_clock_source

`default_nettype wire

// ===== bench/ref_clock_select_and_reset_test.sv
`timescale 1ns/1ns
`default_nettype none

module ref_clock_select_and_reset_test
  import clk_rst_pkg::*;
;
  logic      ref_clk      = 1'b0;
  logic      reset_n      = 1'b1;
  logic [1:0] clkSelStrap = 2'h0;
  logic      diffRun      = 1'b0;
  logic      xtalRun      = 1'b0;
  logic      irqPending   = 1'b0;
  logic      testResetLow = 1'b1;
  logic      diffClk, xtalClk, srcReady, selCrystal;
  logic      coreResetLow, irqOutLowO, irqOutLowOe, scanLogicReset;
  ref_freq_t refFreq;
  int        err_total    = 0;
  int        num_checks   = 0;

  always #4 ref_clk = ~ref_clk;

  board_clock_source board (.ref_clk(ref_clk), .diffRun(diffRun), .xtalRun(xtalRun),
    .diffClk(diffClk), .xtalClk(xtalClk), .srcReady(srcReady));

  ref_clock_select_and_reset DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .clkSelStrap(clkSelStrap), .differentialReferenceClock(diffClk),
    .crystalClockInput(xtalClk), .irqPending(irqPending), .testResetLow(testResetLow),
    .selCrystal(selCrystal), .refFreq(refFreq), .coreResetLow(coreResetLow),
    .irqOutLowO(irqOutLowO), .irqOutLowOe(irqOutLowOe), .scanLogicReset(scanLogicReset));

  task automatic check(input logic [1:0] seen, input logic [1:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Board brings up one source, then releases reset once it has run long enough
  task automatic bring_up(input logic [1:0] code, input logic dRun, input logic xRun);
    int n;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    diffRun <= 1'b0;
    xtalRun <= 1'b0;
    clkSelStrap <= code;
    // Two edges let the model drop a ready flag left from the previous run
    repeat (2) @(posedge ref_clk);
    diffRun <= dRun;
    xtalRun <= xRun;
    n = 0;
    while (srcReady !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    check({1'b0, srcReady}, 2'h1, "source ran long enough before release");
    check(coreResetLow, 2'h0, "core held in reset");
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : bring_up

  task automatic test_strap(input logic [1:0] code, input logic xtal, input ref_freq_t freq);
    int n;
    bring_up(code, ~xtal, xtal);
    check(selCrystal, {1'b0, xtal}, "crystal select");
    check(refFreq, freq, "frequency decode");
    n = 0;
    while (coreResetLow !== 1'b1 && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(coreResetLow, 2'h1, "core reset released");
    check({1'b0, n >= 60}, 2'h1, "release waited for source edges");
  endtask : test_strap

  task automatic test_wrong_source();
    bring_up(SEL_XTAL_25, 1'b1, 1'b0);
    repeat (200) @(posedge ref_clk);
    #1;
    check(coreResetLow, 2'h0, "unselected source ignored");
  endtask : test_wrong_source

  task automatic test_irq();
    int n;
    @(posedge ref_clk);
    irqPending <= 1'b1;
    #1;
    check(irqOutLowOe, 2'h0, "irq not yet driven");
    @(posedge ref_clk);
    #1;
    check({irqOutLowOe, irqOutLowO}, 2'h2, "irq pulls low");
    @(posedge ref_clk);
    reset_n <= 1'b0;
    #1;
    check({coreResetLow, selCrystal}, 2'h0, "async reset entry");
    check({irqOutLowOe, irqOutLowO}, 2'h0, "irq released in reset");
    // Reset is held across one edge before the mid-run release
    @(posedge ref_clk);
    reset_n <= 1'b1;
    irqPending <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({irqOutLowOe, irqOutLowO}, 2'h0, "irq released");
    check(coreResetLow, 2'h0, "core waits for synchronised release");
    @(posedge ref_clk);
    #1;
    check(selCrystal, 2'h1, "strap captured again after release");
    n = 0;
    while (coreResetLow !== 1'b1 && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(coreResetLow, 2'h1, "core back after mid-run reset");
  endtask : test_irq

  task automatic test_scan();
    @(posedge ref_clk);
    testResetLow <= 1'b0;
    #1;
    check(scanLogicReset, 2'h1, "scan held in reset");
    @(posedge ref_clk);
    testResetLow <= 1'b1;
    #1;
    check(scanLogicReset, 2'h0, "scan released");
  endtask : test_scan

  initial
  begin
    // Asserted at time zero so the design is never unknown at the first edge
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    test_scan();
    test_strap(SEL_DIFF_156, 1'b0, FREQ_156M25);
    test_strap(SEL_DIFF_125, 1'b0, FREQ_125M);
    test_strap(SEL_DIFF_25, 1'b0, FREQ_25M);
    test_strap(SEL_XTAL_25, 1'b1, FREQ_25M);
    test_irq();
    test_wrong_source();
    stop_test();
  end

  initial
  begin
    #50000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
endmodule : ref_clock_select_and_reset_test

`default_nettype wire
